// [core/pcbnv_bank.sv]
// command register bank with raw nvm block loading
`timescale 1ns/1ps
`include "pcbnv_params.svh"
module pcbnv_bank
   import pcbnv_pkg::*;
#(
   parameter int unsigned PRG_CYCLES = `PCB_PRG_TIME_MS * `PCB_CLK_KHZ,
   parameter logic [47:0] PART_ID = 48'h0102_0304_0506,
   parameter logic [15:0] PART_REV = 16'h0001
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [7:0] req_code_in,
   input wire logic [255:0] req_data_in,
   input wire logic [7:0] dev_addr_in,
   output logic rsp_valid_out,
   output logic rsp_ack_out,
   output logic [255:0] rsp_data_out,
   output pcbnv_chan_cfg_t [1:0] chan_cfg_out,
   output logic [1:0] fault_clear_out,
   output logic [7:0] mfp_cfg_out,
   output logic nvm_busy_out
);
   // part_identity_bytes and part_revision_bytes defaults are arbitrary values

   localparam int NVM_BYTES = `PCB_NVM_BLK_BYTES * `PCB_NVM_BLKS;
   // block zero carries identity and revision most significant byte first
   localparam logic [47:0] PART_ID_LE = {PART_ID[7:0], PART_ID[15:8], PART_ID[23:16],
                                         PART_ID[31:24], PART_ID[39:32], PART_ID[47:40]};
   localparam logic [15:0] PART_REV_LE = {PART_REV[7:0], PART_REV[15:8]};

   // ==========================================================
   // helpers
   function automatic pcbnv_lookup_t slot_of(input logic [7:0] code, input logic [7:0] sub);
      pcbnv_lookup_t r;
      r.found = 1'b1;
      r.slot = PCBNV_S_RUN;
      case (code)
         `PCB_CMD_RUN: r.slot = PCBNV_S_RUN;
         `PCB_CMD_ENSRC: r.slot = PCBNV_S_ENSRC;
         `PCB_CMD_PHASE: r.slot = PCBNV_S_PHASE;
         `PCB_CMD_VTGT: r.slot = PCBNV_S_VTGT;
         `PCB_CMD_VTRIM: r.slot = PCBNV_S_VTRIM;
         `PCB_CMD_VMAX: r.slot = PCBNV_S_VMAX;
         `PCB_CMD_MHI: r.slot = PCBNV_S_MHI;
         `PCB_CMD_MLO: r.slot = PCBNV_S_MLO;
         `PCB_CMD_SLEW: r.slot = PCBNV_S_SLEW;
         `PCB_CMD_DROOP: r.slot = PCBNV_S_DROOP;
         `PCB_CMD_SCALE: r.slot = PCBNV_S_SCALE;
         `PCB_CMD_VMIN: r.slot = PCBNV_S_VMIN;
         `PCB_CMD_FSW: r.slot = PCBNV_S_FSW;
         `PCB_CMD_PMODE: r.slot = PCBNV_S_PMODE;
         `PCB_CMD_VINON: r.slot = PCBNV_S_VINON;
         `PCB_CMD_AMASK:
         begin
            case (sub)
               `PCB_ST_WORD: r.slot = PCBNV_S_MWORD;
               `PCB_ST_VOUT: r.slot = PCBNV_S_MVOUT;
               `PCB_ST_IOUT: r.slot = PCBNV_S_MIOUT;
               `PCB_ST_INPUT: r.slot = PCBNV_S_MIN;
               `PCB_ST_TEMP: r.slot = PCBNV_S_MTEMP;
               `PCB_ST_CML: r.slot = PCBNV_S_MCML;
               `PCB_ST_MFR: r.slot = PCBNV_S_MMFR;
               default: r.found = 1'b0;
            endcase
         end
         default: r.found = 1'b0;
      endcase
      return r;
   endfunction : slot_of

   // settings that survive in nvm; run, phase, the status word mask, margins and phase mode do not
   function automatic logic storable(input pcbnv_slot_t sl);
      return !(sl inside {PCBNV_S_RUN, PCBNV_S_PHASE, PCBNV_S_MWORD, PCBNV_S_MHI,
                          PCBNV_S_MLO, PCBNV_S_PMODE});
   endfunction : storable

   function automatic logic is_word(input pcbnv_slot_t sl);
      return sl inside {[PCBNV_S_VTGT:PCBNV_S_FSW], PCBNV_S_VINON};
   endfunction : is_word

   function automatic logic [8:0] nvm_pos(input int ch, input int sl);
      return 9'(`PCB_NVM_SLOT_BASE + 9'(ch) * `PCB_NVM_CH_STRIDE + 9'(sl * 2));
   endfunction : nvm_pos

   function automatic logic [15:0] dflt(input int ch, input int sl);
      case (pcbnv_slot_t'(sl))
         PCBNV_S_RUN: return `PCB_RST_RUN;
         PCBNV_S_ENSRC: return `PCB_RST_ENSRC;
         PCBNV_S_PHASE: return `PCB_RST_PHASE;
         PCBNV_S_MIN: return `PCB_RST_MASK_IN;
         PCBNV_S_MMFR: return (ch == 0) ? `PCB_RST_MASK_MFR_A : `PCB_RST_MASK_MFR_B;
         PCBNV_S_VTGT: return (ch == 0) ? `PCB_RST_VTGT_A : `PCB_RST_VTGT_B;
         PCBNV_S_VMAX: return (ch == 0) ? `PCB_RST_VMAX_A : `PCB_RST_VMAX_B;
         PCBNV_S_SLEW: return `PCB_RST_SLEW;
         PCBNV_S_DROOP: return `PCB_RST_DROOP;
         PCBNV_S_SCALE: return `PCB_RST_SCALE;
         PCBNV_S_FSW: return `PCB_RST_FSW;
         PCBNV_S_PMODE: return `PCB_RST_PMODE;
         PCBNV_S_VINON: return `PCB_RST_VINON;
         default: return 16'h0000;
      endcase
   endfunction : dflt

   function automatic pcbnv_state_t reset_state();
      pcbnv_state_t r;
      r = '0;
      r.fsm = PCBNV_BOOT;
      r.page = `PCB_PAGE_ALL;
      r.lock = `PCB_RST_LOCK;
      for (int c = 0; c < 2; c++)
      begin
         for (int k = 0; k < `PCB_NSLOT; k++)
         begin
            r.regs[c][k] = dflt(c, k);
         end
      end
      return r;
   endfunction : reset_state

   localparam pcbnv_state_t RST_STATE = reset_state();

   // writes allowed under each write lock level
   function automatic logic lock_ok(input logic [7:0] lk, input logic [7:0] code);
      case (lk)
         `PCB_LOCK_ALL: return code == `PCB_CMD_LOCK;
         `PCB_LOCK_RUN:
            return code inside {`PCB_CMD_LOCK, `PCB_CMD_PAGE, `PCB_CMD_RUN};
         `PCB_LOCK_VOUT:
            return code inside {`PCB_CMD_LOCK, `PCB_CMD_PAGE, `PCB_CMD_RUN,
                                `PCB_CMD_ENSRC, `PCB_CMD_VTGT};
         default: return 1'b1;
      endcase
   endfunction : lock_ok

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // command handling
   logic [7:0] nvm_q [NVM_BYTES];
   pcbnv_state_t s_q;
   pcbnv_state_t s_d;
   logic blk_we;
   logic save_go;
   logic [7:0] code;
   logic [7:0] page;
   logic [255:0] data;
   logic [1:0] chans;
   logic rch;
   logic chk_ok;
   logic id_skip;
   logic rev_skip;
   logic all_skip;
   logic [8:0] base;
   pcbnv_lookup_t lk;

   always_comb
   begin
      s_d = s_q;
      s_d.rsp_valid = 1'b0;
      s_d.fclr = 2'b00;
      blk_we = 1'b0;
      save_go = 1'b0;
      code = req_code_in;
      page = s_q.page;
      data = req_data_in;
      // the wrapper carries page then inner code; the page register is untouched
      if (req_code_in == `PCB_CMD_PGWR || req_code_in == `PCB_CMD_PGRD)
      begin
         page = req_data_in[7:0];
         code = req_data_in[15:8];
         data = req_data_in >> 16;
      end
      chans = (page == `PCB_PAGE_ALL) ? 2'b11 : ((page == `PCB_PAGE_B) ? 2'b10 : 2'b01);
      rch = (page == `PCB_PAGE_B);
      lk = slot_of(code, data[7:0]);
      base = 9'({s_q.idx, 5'h00});
      all_skip = 1'b1;
      id_skip = 1'b1;
      rev_skip = 1'b1;
      for (int b = 0; b <= `PCB_NVM_ADDR_POS; b++)
      begin
         if (data[b*8 +: 8] != `PCB_NVM_SKIP_BYTE)
         begin
            all_skip = 1'b0;
            if (b < `PCB_NVM_ID_BYTES)
               id_skip = 1'b0;
            else if (b < `PCB_NVM_ADDR_POS)
               rev_skip = 1'b0;
         end
      end
      chk_ok = all_skip ||
         ((id_skip || data[47:0] == PART_ID_LE) &&
          (rev_skip || data[63:48] == PART_REV_LE) &&
          data[`PCB_NVM_ADDR_POS*8 +: 8] == dev_addr_in);

      case (s_q.fsm)
         PCBNV_BOOT:
         begin
            // power-up load; pin configuration is taken only here
            if (nvm_q[`PCB_NVM_MARK_POS] == `PCB_NVM_MARK_VAL)
            begin
               for (int c = 0; c < 2; c++)
               begin
                  for (int k = 0; k < `PCB_NSLOT; k++)
                  begin
                     if (storable(pcbnv_slot_t'(k)))
                        s_d.regs[c][k] = {nvm_q[nvm_pos(c, k) + 9'h001], nvm_q[nvm_pos(c, k)]};
                  end
               end
               s_d.lock = nvm_q[`PCB_NVM_LOCK_POS];
               s_d.mfp = nvm_q[`PCB_NVM_MFP_POS];
            end
            s_d.fsm = PCBNV_IDLE;
         end
         PCBNV_PROG:
         begin
            // nvm is being programmed; every request is refused
            s_d.cnt = s_q.cnt - 32'h0000_0001;
            if (s_q.cnt == 32'h0000_0001)
               s_d.fsm = PCBNV_IDLE;
         end
         PCBNV_IDLE:
         begin
            if (req_valid_in && req_write_in)
            begin
               s_d.rsp_ack = lock_ok(s_q.lock, code);
               if (lock_ok(s_q.lock, code))
               begin
                  case (code)
                     `PCB_CMD_PAGE:
                     begin
                        if (data[7:0] inside {`PCB_PAGE_A, `PCB_PAGE_B, `PCB_PAGE_ALL})
                           s_d.page = data[7:0];
                        else
                           s_d.rsp_ack = 1'b0;
                     end
                     `PCB_CMD_FCLR: s_d.fclr = chans;
                     `PCB_CMD_LOCK:
                     begin
                        if (data[7:0] inside {`PCB_RST_LOCK, `PCB_LOCK_ALL, `PCB_LOCK_RUN,
                                              `PCB_LOCK_VOUT})
                           s_d.lock = data[7:0];
                        else
                           s_d.rsp_ack = 1'b0;
                     end
                     `PCB_CMD_SAVE:
                     begin
                        save_go = 1'b1;
                        s_d.fsm = PCBNV_PROG;
                        s_d.cnt = PRG_CYCLES;
                     end
                     `PCB_CMD_RELOAD:
                     begin
                        for (int c = 0; c < 2; c++)
                        begin
                           for (int k = 0; k < `PCB_NSLOT; k++)
                           begin
                              if (storable(pcbnv_slot_t'(k)))
                                 s_d.regs[c][k] = {nvm_q[nvm_pos(c, k) + 9'h001],
                                                   nvm_q[nvm_pos(c, k)]};
                           end
                        end
                        s_d.lock = nvm_q[`PCB_NVM_LOCK_POS];
                     end
                     `PCB_CMD_NIDX:
                     begin
                        if (data[7:4] == 4'h0 && data[3:0] <= `PCB_NVM_LAST_IDX)
                           s_d.idx = data[3:0];
                        else
                           s_d.rsp_ack = 1'b0;
                     end
                     `PCB_CMD_NACC:
                     begin
                        if (s_q.idx == 4'h0 && !chk_ok)
                           s_d.rsp_ack = 1'b0;
                        else if (s_q.idx == `PCB_NVM_LAST_IDX)
                        begin
                           blk_we = 1'b1;
                           s_d.idx = 4'h0;
                           s_d.fsm = PCBNV_PROG;
                           s_d.cnt = PRG_CYCLES;
                        end
                        else
                        begin
                           blk_we = 1'b1;
                           s_d.idx = s_q.idx + 4'h1;
                        end
                     end
                     `PCB_CMD_FEAT, `PCB_CMD_VFMT, `PCB_CMD_PGRD: ;
                     default:
                     begin
                        if (lk.found)
                        begin
                           for (int c = 0; c < 2; c++)
                           begin
                              if (chans[c] && code == `PCB_CMD_AMASK)
                                 s_d.regs[c][lk.slot] = {8'h00, data[15:8]};
                              else if (chans[c])
                                 s_d.regs[c][lk.slot] = is_word(lk.slot) ? data[15:0]
                                                                         : {8'h00, data[7:0]};
                           end
                        end
                        else
                           s_d.rsp_ack = 1'b0;
                     end
                  endcase
               end
            end
            else if (req_valid_in)
            begin
               s_d.rsp_ack = 1'b1;
               s_d.rsp_data = '0;
               case (code)
                  `PCB_CMD_PAGE: s_d.rsp_data[7:0] = s_q.page;
                  `PCB_CMD_LOCK: s_d.rsp_data[7:0] = s_q.lock;
                  `PCB_CMD_FEAT: s_d.rsp_data[7:0] = `PCB_FEAT_VAL;
                  `PCB_CMD_VFMT: s_d.rsp_data[7:0] = `PCB_VFMT_VAL;
                  `PCB_CMD_NIDX: s_d.rsp_data[3:0] = s_q.idx;
                  `PCB_CMD_NACC:
                  begin
                     for (int b = 0; b < `PCB_NVM_BLK_BYTES; b++)
                     begin
                        s_d.rsp_data[b*8 +: 8] = nvm_q[base + 9'(b)];
                     end
                     s_d.idx = (s_q.idx == `PCB_NVM_LAST_IDX) ? 4'h0 : s_q.idx + 4'h1;
                  end
                  default:
                  begin
                     if (lk.found)
                        s_d.rsp_data[15:0] = s_q.regs[rch][lk.slot];
                     else
                        s_d.rsp_ack = 1'b0;
                  end
               endcase
            end
         end
         default: s_d.fsm = PCBNV_IDLE;
      endcase

      if (req_valid_in)
      begin
         s_d.rsp_valid = 1'b1;
         if (s_q.fsm != PCBNV_IDLE)
         begin
            s_d.rsp_ack = 1'b0;
            s_d.rsp_data = '0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= RST_STATE;
      else if (ce_in)
         s_q <= s_d;
   end

   // ==========================================================
   // nvm array; holds its contents across reset like the real cells
   always_ff @(posedge clk_in)
   begin
      if (ce_in && rst_n && blk_we)
      begin
         for (int b = 0; b < `PCB_NVM_BLK_BYTES; b++)
         begin
            nvm_q[base + 9'(b)] <= data[b*8 +: 8];
         end
      end
      else if (ce_in && rst_n && save_go)
      begin
         for (int c = 0; c < 2; c++)
         begin
            for (int k = 0; k < `PCB_NSLOT; k++)
            begin
               if (storable(pcbnv_slot_t'(k)))
               begin
                  nvm_q[nvm_pos(c, k)] <= s_q.regs[c][k][7:0];
                  nvm_q[nvm_pos(c, k) + 9'h001] <= s_q.regs[c][k][15:8];
               end
            end
         end
         nvm_q[`PCB_NVM_LOCK_POS] <= s_q.lock;
         nvm_q[`PCB_NVM_MARK_POS] <= `PCB_NVM_MARK_VAL;
      end
   end

   // ==========================================================
   // outputs
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         chan_cfg_out[c].run = s_q.regs[c][PCBNV_S_RUN][7:0];
         chan_cfg_out[c].ensrc = s_q.regs[c][PCBNV_S_ENSRC][7:0];
         chan_cfg_out[c].phase = s_q.regs[c][PCBNV_S_PHASE][7:0];
         chan_cfg_out[c].pmode = s_q.regs[c][PCBNV_S_PMODE][7:0];
         chan_cfg_out[c].vtgt = s_q.regs[c][PCBNV_S_VTGT];
         chan_cfg_out[c].fsw = s_q.regs[c][PCBNV_S_FSW];
      end
   end

   assign rsp_valid_out = s_q.rsp_valid;
   assign rsp_ack_out = s_q.rsp_ack;
   assign rsp_data_out = s_q.rsp_data;
   assign fault_clear_out = s_q.fclr;
   assign mfp_cfg_out = s_q.mfp;
   assign nvm_busy_out = (s_q.fsm == PCBNV_PROG);
endmodule : pcbnv_bank

// [core/pcbnv_params.svh]
// command codes, reset values, nvm layout and timing of the command bank
`ifndef PCBNV_PARAMS_SVH
`define PCBNV_PARAMS_SVH
`define PCB_CMD_PAGE 8'h00
`define PCB_CMD_RUN 8'h01
`define PCB_CMD_ENSRC 8'h02
`define PCB_CMD_FCLR 8'h03
`define PCB_CMD_PHASE 8'h04
`define PCB_CMD_PGWR 8'h05
`define PCB_CMD_PGRD 8'h06
`define PCB_CMD_LOCK 8'h10
`define PCB_CMD_SAVE 8'h15
`define PCB_CMD_RELOAD 8'h16
`define PCB_CMD_FEAT 8'h19
`define PCB_CMD_AMASK 8'h1b
`define PCB_CMD_VFMT 8'h20
`define PCB_CMD_VTGT 8'h21
`define PCB_CMD_VTRIM 8'h22
`define PCB_CMD_VMAX 8'h24
`define PCB_CMD_MHI 8'h25
`define PCB_CMD_MLO 8'h26
`define PCB_CMD_SLEW 8'h27
`define PCB_CMD_DROOP 8'h28
`define PCB_CMD_SCALE 8'h29
`define PCB_CMD_VMIN 8'h2b
`define PCB_CMD_FSW 8'h33
`define PCB_CMD_PMODE 8'h34
`define PCB_CMD_VINON 8'h35
`define PCB_CMD_NIDX 8'hf5
`define PCB_CMD_NACC 8'hf6
// status group codes that select one alert mask under the mask command
`define PCB_ST_WORD 8'h79
`define PCB_ST_VOUT 8'h7a
`define PCB_ST_IOUT 8'h7b
`define PCB_ST_INPUT 8'h7c
`define PCB_ST_TEMP 8'h7d
`define PCB_ST_CML 8'h7e
`define PCB_ST_MFR 8'h80
`define PCB_PAGE_A 8'h00
`define PCB_PAGE_B 8'h01
`define PCB_PAGE_ALL 8'hff
`define PCB_RST_RUN 16'h0000
`define PCB_RST_ENSRC 16'h0017
`define PCB_RST_PHASE 16'h00ff
`define PCB_RST_LOCK 8'h00
`define PCB_RST_MASK_IN 16'h0008
`define PCB_RST_MASK_MFR_A 16'h0026
`define PCB_RST_MASK_MFR_B 16'h0006
`define PCB_RST_VTGT_A 16'h0385
`define PCB_RST_VTGT_B 16'h0400
`define PCB_RST_VMAX_A 16'h077a
`define PCB_RST_VMAX_B 16'h059a
`define PCB_RST_SLEW 16'he050
`define PCB_RST_DROOP 16'hc800
`define PCB_RST_SCALE 16'he808
`define PCB_RST_FSW 16'h01f4
`define PCB_RST_PMODE 16'h0003
`define PCB_RST_VINON 16'hf025
`define PCB_FEAT_VAL 8'hd0
`define PCB_VFMT_VAL 8'h16
`define PCB_LOCK_ALL 8'h80
`define PCB_LOCK_RUN 8'h40
`define PCB_LOCK_VOUT 8'h20
`define PCB_NVM_BLK_BYTES 32
`define PCB_NVM_BLKS 9
`define PCB_NVM_LAST_IDX 4'h8
`define PCB_NVM_ID_BYTES 6
`define PCB_NVM_REV_POS 6
`define PCB_NVM_ADDR_POS 8
`define PCB_NVM_SKIP_BYTE 8'hff
`define PCB_NVM_SLOT_BASE 9'h009
`define PCB_NVM_CH_STRIDE 9'h040
`define PCB_NVM_LOCK_POS 9'h08c
`define PCB_NVM_MFP_POS 9'h08d
`define PCB_NVM_MARK_POS 9'h08e
`define PCB_NVM_MARK_VAL 8'ha5
`define PCB_PRG_TIME_MS 100
`define PCB_CLK_KHZ 40000
`define PCB_NSLOT 22
`endif

// [core/pcbnv_pkg.sv]
// types of the command bank: slots, state machine, carriers and state record
`include "pcbnv_params.svh"
package pcbnv_pkg;
   typedef enum logic [4:0] {
      PCBNV_S_RUN, PCBNV_S_ENSRC, PCBNV_S_PHASE, PCBNV_S_MWORD, PCBNV_S_MVOUT,
      PCBNV_S_MIOUT, PCBNV_S_MIN, PCBNV_S_MTEMP, PCBNV_S_MCML, PCBNV_S_MMFR,
      PCBNV_S_VTGT, PCBNV_S_VTRIM, PCBNV_S_VMAX, PCBNV_S_MHI, PCBNV_S_MLO,
      PCBNV_S_SLEW, PCBNV_S_DROOP, PCBNV_S_SCALE, PCBNV_S_VMIN, PCBNV_S_FSW,
      PCBNV_S_PMODE, PCBNV_S_VINON
   } pcbnv_slot_t;

   typedef enum logic [2:0] {
      PCBNV_BOOT = 3'b001,
      PCBNV_IDLE = 3'b010,
      PCBNV_PROG = 3'b100
   } pcbnv_fsm_t;

   typedef struct packed {
      logic [7:0] run;
      logic [7:0] ensrc;
      logic [7:0] phase;
      logic [7:0] pmode;
      logic [15:0] vtgt;
      logic [15:0] fsw;
   } pcbnv_chan_cfg_t;

   typedef struct packed {
      logic found;
      pcbnv_slot_t slot;
   } pcbnv_lookup_t;

   typedef struct packed {
      pcbnv_fsm_t fsm;
      logic [7:0] page;
      logic [7:0] lock;
      logic [7:0] mfp;
      logic [3:0] idx;
      logic [31:0] cnt;
      logic [1:0][`PCB_NSLOT-1:0][15:0] regs;
      logic rsp_valid;
      logic rsp_ack;
      logic [255:0] rsp_data;
      logic [1:0] fclr;
   } pcbnv_state_t;
endpackage : pcbnv_pkg

// [testbench/pcbnv_host.sv]
// host model issuing one bank request at a time
`timescale 1ns/1ps
module pcbnv_host
(
   input wire logic clk_in,
   input wire logic rsp_valid_in,
   input wire logic rsp_ack_in,
   input wire logic [255:0] rsp_data_in,
   output logic req_valid_out,
   output logic req_write_out,
   output logic [7:0] req_code_out,
   output logic [255:0] req_data_out
);
   initial
   begin
      req_valid_out = 1'b0;
      req_write_out = 1'b0;
      req_code_out = 8'h00;
      req_data_out = '0;
   end
   // idle payload is inverted so stale data is never mistaken for a request
   task xfer(input logic wr, input logic [7:0] code, input logic [255:0] data,
      output logic ack, output logic [255:0] rd);
      @(negedge clk_in);
      req_valid_out = 1'b1;
      req_write_out = wr;
      req_code_out = code;
      req_data_out = data;
      @(negedge clk_in);
      ack = rsp_valid_in & rsp_ack_in;
      rd = rsp_data_in;
      req_valid_out = 1'b0;
      req_data_out = ~data;
   endtask : xfer
endmodule : pcbnv_host

// [testbench/pcbnv_bank_assertions.sv]
// port assertions of the command bank
`timescale 1ns/1ps
module pcbnv_bank_assertions
   import pcbnv_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [7:0] req_code_in,
   input wire logic [255:0] req_data_in,
   input wire logic [7:0] dev_addr_in,
   input wire logic rsp_valid_out,
   input wire logic rsp_ack_out,
   input wire logic [255:0] rsp_data_out,
   input wire pcbnv_chan_cfg_t [1:0] chan_cfg_out,
   input wire logic [1:0] fault_clear_out,
   input wire logic [7:0] mfp_cfg_out,
   input wire logic nvm_busy_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_answer_next: assert property (ce_in && req_valid_in |=> rsp_valid_out)
      else $error("request got no answer");
   a_answer_caused: assert property (rsp_valid_out |-> $past(req_valid_in))
      else $error("answer without request");
   a_ro_write_acked: assert property (req_valid_in && req_write_in && req_code_in == 8'h19
      && !nvm_busy_out |=> rsp_ack_out) else $error("read-only write refused");
   a_feature_code: assert property (req_valid_in && !req_write_in && req_code_in == 8'h19
      |=> (rsp_ack_out -> rsp_data_out[7:0] == 8'hd0)) else $error("feature byte wrong");
   a_clear_cause: assert property (fault_clear_out != 2'b00 |->
      $past(req_valid_in && req_write_in && req_code_in == 8'h03, 1)
      || $past(req_valid_in && req_write_in && req_code_in == 8'h03, 2))
      else $error("fault clear without command");
   a_store_cause: assert property ($rose(nvm_busy_out) |-> $past(req_valid_in && req_write_in
      && (req_code_in == 8'hf6 || req_code_in == 8'h15))) else $error("store without cause");
   a_busy_refuse: assert property (nvm_busy_out && req_valid_in |=> !rsp_ack_out)
      else $error("request accepted while busy");
   a_reload_pins: assert property (req_valid_in && req_write_in && req_code_in == 8'h16
      |=> $stable(mfp_cfg_out)) else $error("reload changed pin config");
endmodule : pcbnv_bank_assertions
bind pcbnv_bank pcbnv_bank_assertions i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_code_in(req_code_in),
   .req_data_in(req_data_in), .dev_addr_in(dev_addr_in), .rsp_valid_out(rsp_valid_out),
   .rsp_ack_out(rsp_ack_out), .rsp_data_out(rsp_data_out), .chan_cfg_out(chan_cfg_out),
   .fault_clear_out(fault_clear_out), .mfp_cfg_out(mfp_cfg_out), .nvm_busy_out(nvm_busy_out));

// [testbench/pcbnv_bank_tb.sv]
// self-checking bench of the command bank
`timescale 1ns/1ps
module pcbnv_bank_tb;
   localparam int PRG = 20;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce = 1'b1;
   logic req_valid, req_write, rsp_valid, rsp_ack, busy, ack;
   logic [7:0] req_code, mfp;
   logic [255:0] req_data, rsp_data, rd;
   logic [1:0] fclr;
   logic [1:0] fseen = 2'b00;
   pcbnv_pkg::pcbnv_chan_cfg_t [1:0] cfg;
   int fail_count = 0;
   int samples_checked = 0;
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) fseen <= fseen | fclr;
   pcbnv_bank #(.PRG_CYCLES(PRG)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .req_valid_in(req_valid), .req_write_in(req_write), .req_code_in(req_code),
      .req_data_in(req_data), .dev_addr_in(8'h60), .rsp_valid_out(rsp_valid),
      .rsp_ack_out(rsp_ack), .rsp_data_out(rsp_data), .chan_cfg_out(cfg),
      .fault_clear_out(fclr), .mfp_cfg_out(mfp), .nvm_busy_out(busy));
   pcbnv_host i_host (.clk_in(clk_in), .rsp_valid_in(rsp_valid), .rsp_ack_in(rsp_ack),
      .rsp_data_in(rsp_data), .req_valid_out(req_valid), .req_write_out(req_write),
      .req_code_out(req_code), .req_data_out(req_data));
   task chk(input logic [255:0] seen, input logic [255:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] code, input logic [255:0] data, input logic exp_ack);
      i_host.xfer(1'b1, code, data, ack, rd);
      chk(ack, exp_ack);
   endtask : wr
   task rdc(input logic [7:0] code, input logic [255:0] data, input logic [255:0] exp);
      i_host.xfer(1'b0, code, data, ack, rd);
      chk(ack, 1'b1);
      chk(rd, exp);
   endtask : rdc
   // byte value is its nvm position, except the nine skip bytes of block zero and the zeroed tail of block eight, with lock cleared and the valid mark set
   function automatic logic [255:0] blkval(input int i);
      logic [255:0] v;
      for (int b = 0; b < 32; b++)
         v[b*8 +: 8] = (i == 0 && b < 9) ? 8'hff : (i == 8 && b > 8) ? 8'h00 :
            (i*32+b == 140) ? 8'h00 : (i*32+b == 142) ? 8'ha5 : 8'(i*32+b);
      return v;
   endfunction : blkval
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial
   begin
      #(3000 * 25);
      fail_count++;
      wrap_up();
   end
   initial
   begin
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (5) @(negedge clk_in);
      rdc(8'h00, 0, 8'hff);
      rdc(8'h01, 0, 8'h00);
      rdc(8'h02, 0, 8'h17);
      rdc(8'h04, 0, 8'hff);
      rdc(8'h10, 0, 8'h00);
      rdc(8'h34, 0, 8'h03);
      rdc(8'h33, 0, 16'h01f4);
      rdc(8'h1b, 8'h7c, 8'h08);
      rdc(8'h1b, 8'h80, 8'h26);
      rdc(8'h06, 24'h801b01, 8'h06);
      chk(cfg, {8'h00, 8'h17, 8'hff, 8'h03, 16'h0400, 16'h01f4,
         8'h00, 8'h17, 8'hff, 8'h03, 16'h0385, 16'h01f4});
      $display("test defaults done");
      wr(8'h19, 0, 1'b1);
      rdc(8'h19, 0, 8'hd0);
      wr(8'h20, 0, 1'b1);
      rdc(8'h20, 0, 8'h16);
      wr(8'h05, 32'h01232101, 1'b1);
      chk({cfg[1].vtgt, cfg[0].vtgt}, 32'h01230385);
      rdc(8'h06, 16'h2100, 16'h0385);
      wr(8'h00, 8'h01, 1'b1);
      wr(8'h03, 0, 1'b1);
      // the clear pulse stands one cycle; the sticky copy lags it by one edge
      chk({fseen, fclr}, 4'b0010);
      wr(8'h00, 8'h00, 1'b1);
      wr(8'h03, 0, 1'b1);
      chk({fseen, fclr}, 4'b1001);
      wr(8'h00, 8'hff, 1'b1);
      wr(8'h03, 0, 1'b1);
      chk(fclr, 2'b11);
      // a request while the clock enable is low must not be taken
      @(negedge clk_in);
      ce = 1'b0;
      wr(8'h01, 8'h80, 1'b0);
      ce = 1'b1;
      rdc(8'h01, 0, 8'h00);
      $display("test commands done");
      chk(cfg[0].run | cfg[1].run, 0);
      wr(8'hf5, 0, 1'b1);
      wr(8'hf6, 0, 1'b0);
      wr(8'hf6, {8'h61, {8{8'hff}}}, 1'b0);
      wr(8'hf6, {8'h60, {8{8'hff}}}, 1'b1);
      wr(8'hf5, 0, 1'b1);
      for (int i = 0; i < 9; i++)
         wr(8'hf6, blkval(i), 1'b1);
      chk(busy, 1'b1);
      wr(8'h01, 0, 1'b0);
      repeat (PRG) @(negedge clk_in);
      chk(busy, 1'b0);
      // no save here, it would overwrite the loaded image
      wr(8'hf5, 0, 1'b1);
      rdc(8'hf6, 0, blkval(0));
      rdc(8'hf6, 0, blkval(1));
      wr(8'h16, 0, 1'b1);
      chk({mfp, cfg[0].vtgt, cfg[0].fsw}, 40'h00_1e1d_302f);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (5) @(negedge clk_in);
      chk(mfp, 8'h8d);
      $display("test nvm load done");
      wr(8'h21, 16'h0300, 1'b1);
      wr(8'h15, 0, 1'b1);
      repeat (PRG + 2) @(negedge clk_in);
      wr(8'h21, 16'h0111, 1'b1);
      wr(8'h16, 0, 1'b1);
      chk(cfg[0].vtgt, 16'h0300);
      $display("test save done");
      wrap_up();
   end
endmodule : pcbnv_bank_tb
